// file: design/sscc_regs.svh
// Purpose: Register map, field positions, reset values and counts.
// Assumes: Printed offsets are register indices; byte address is 4 x index.
// Notes:   Definitions only.
`ifndef SSCC_REGS_SVH
`define SSCC_REGS_SVH

// Register indices (word address bits [7:2])
`define SSCC_IDX_PLL_ONE      6'h18
`define SSCC_IDX_PLL_TWO      6'h19
`define SSCC_IDX_SHAPE        6'h1a
`define SSCC_IDX_LOAD_RESETS  6'h1b
`define SSCC_IDX_STATUS       6'h20

// Reset values
`define SSCC_RST_PLL_ONE      8'hf8
`define SSCC_RST_PLL_TWO      8'h18
`define SSCC_RST_SHAPE        8'h00
`define SSCC_RST_LOAD_RESETS  8'h02

// Range / pump / filter fields
`define SSCC_RANGE_MSB        7
`define SSCC_RANGE_LSB        5
`define SSCC_PUMP_MSB         4
`define SSCC_PUMP_LSB         3
`define SSCC_FILT_MSB         2
`define SSCC_FILT_LSB         0

// Spread shape and enable fields
`define SSCC_RATE_MSB         7
`define SSCC_RATE_LSB         6
`define SSCC_BOOST_BIT        5
`define SSCC_GAIN_BIT         4
`define SSCC_WIDTH_MSB        3
`define SSCC_WIDTH_LSB        2
`define SSCC_SYNC_EN_BIT      1
`define SSCC_ENABLE_BIT       0

// Load and line reset fields
`define SSCC_LOAD_BIT         7
`define SSCC_FIFO_LINE_BIT    6
`define SSCC_WAVE_LINE_BIT    5
`define SSCC_LOCK2_OVR_BIT    4
`define SSCC_LOCK1_OVR_BIT    3
`define SSCC_MAX_RATE_BIT     2
`define SSCC_MODE_MSB         1
`define SSCC_MODE_LSB         0

// Mode codes
`define SSCC_MODE_OUT_MULT    2'h0
`define SSCC_MODE_ALL_MULT    2'h1
`define SSCC_MODE_OFF         2'h2
`define SSCC_MODE_ALL_NOMULT  2'h3

// Rate codes
`define SSCC_RATE_X1          2'h0
`define SSCC_RATE_X2          2'h1
`define SSCC_RATE_X4          2'h2

// Total spread in units of 0.3125 %, per width code
`define SSCC_WIDTH_5P0        6'h10
`define SSCC_WIDTH_2P5        6'h08
`define SSCC_WIDTH_1P25       6'h04
`define SSCC_WIDTH_0P625      6'h02

// AXI responses
`define SSCC_RESP_OKAY        2'h0
`define SSCC_RESP_SLVERR      2'h2

// Base modulation step period in aclk cycles at 1x
`define SSCC_TICK_CYCLES      64

`endif

// file: design/sscc_pkg.sv
// Purpose: Types shared by the spread clock control files.
// Assumes: Constants live in sscc_regs.svh.
// Notes:   One-hot start sequencer and packed state records.
package sscc_pkg;

  typedef enum logic [2:0]
  {
    SSCC_IDLE      = 3'b001,
    SSCC_WAIT_SYNC = 3'b010,
    SSCC_RUN       = 3'b100
  } sscc_state_e;

  typedef struct packed
  {
    logic              aw_held;
    logic [5:0]        aw_idx;
    logic              w_held;
    logic [7:0]        w_data;
    logic              w_lane0;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [1:0]        rresp;
    logic [7:0]        rdata;
    logic [7:0]        pll_one;
    logic [7:0]        pll_two;
    logic [7:0]        shape;
    logic [7:0]        load_resets;
    logic              load_pulse;
    logic              fifo_reset;
    logic              wave_reset;
    sscc_state_e       seq;
  } sscc_main_s;

  typedef struct packed
  {
    logic [7:0]        tick_cnt;
    logic [6:0]        position;
    logic              going_up;
  } sscc_wave_s;

endpackage

// file: design/sscc_spread_wave.sv
// Purpose: Triangle modulation waveform for the spread clock.
// Assumes: Amplitude changes move the upper turn at the next step; reset recentres on amp.
// Notes:   Position is unsigned; the nominal frequency sits at amp.
`timescale 1ns/100ps
`include "sscc_regs.svh"
module sscc_spread_wave
#(
  parameter int TICK_CYCLES = `SSCC_TICK_CYCLES
)
(
  // Clock, reset, enable
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       ce,
  // Control
  input  wire logic       run,
  input  wire logic       wave_reset,
  input  wire logic [5:0] amp,
  input  wire logic [1:0] rate_shift,
  input  wire logic       max_rate,
  // Waveform
  output logic      [6:0] position
);
  import sscc_pkg::*;

  sscc_wave_s st;
  sscc_wave_s next_st;
  logic [7:0] tick_last;
  logic [6:0] top;

  always_comb
  begin
    next_st   = st;
    tick_last = 8'((TICK_CYCLES >> rate_shift) - 1);
    top       = {amp, 1'b0};
    if (wave_reset || !run)
    begin
      next_st.tick_cnt = 8'h00;
      next_st.position = {1'b0, amp};
      next_st.going_up = 1'b1;
    end
    else if (max_rate || st.tick_cnt >= tick_last)
    begin
      next_st.tick_cnt = 8'h00;
      if (st.going_up)
      begin
        if (st.position >= top)
        begin
          next_st.going_up = 1'b0;
          next_st.position = st.position - 7'h01;
        end
        else
          next_st.position = st.position + 7'h01;
      end
      else
      begin
        if (st.position == 7'h00)
        begin
          next_st.going_up = 1'b1;
          next_st.position = 7'h01;
        end
        else
          next_st.position = st.position - 7'h01;
      end
    end
    else
      next_st.tick_cnt = st.tick_cnt + 8'h01;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      st <= '{tick_cnt: 8'h00, position: 7'h00, going_up: 1'b1};
    else if (ce)
      st <= next_st;
  end

  assign position = st.position;

endmodule // sscc_spread_wave

// file: design/sscc_top.sv
// Purpose: Spread clock generator and loop configuration over AXI4-Lite.
// Assumes: line_sync_pulse is synchronous to aclk, one cycle per line.
// Notes:
// Contract
// R1 - Master range applies to both loops
// R2 - Loop one pump 11, filter 000 reset
// R3 - Software sets loop two pump 00
// R4 - Software sets loop two filter 111
// R5 - Rate multiplier codes 1x, 2x, 4x
// R6 - Software limits line setting at 4x
// R7 - Boost selects divide step 1/28 or 1/56
// R8 - Gain bit doubles chosen spread width
// R9 - Width code sets total centred spread
// R10 - Sync enable waits for first line
// R11 - Enable bit; rising edge loads machine
// R12 - Load bit loads machine, self clears
// R13 - FIFO reset at start or each line
// R14 - Software uses line FIFO reset sparingly
// R15 - Line pulse optionally resets waveform
// R16 - Mode field selects loop and spread use
// R17 - Software forces loop two lock
// R18 - Load bit reads zero after pulse
// R19 - Reserved rate code acts as 1x
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/100ps
`include "sscc_regs.svh"
module sscc_top
#(
  parameter int ADDR_W      = 8,
  parameter int TICK_CYCLES = `SSCC_TICK_CYCLES
)
(
  // Clock, reset, enable
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              ce,
  // AXI4-Lite write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Line timing
  input  wire logic              line_sync_pulse,
  // Loop configuration
  output logic [2:0]             pll_range,
  output logic [1:0]             first_multiplier_loop_pump,
  output logic [2:0]             first_multiplier_loop_filter,
  output logic [1:0]             second_multiplier_loop_pump,
  output logic [2:0]             second_multiplier_loop_filter,
  output logic                   first_multiplier_loop_lock_force,
  output logic                   second_multiplier_loop_lock_force,
  output logic                   pll_enable,
  output logic                   multiply_enable,
  output logic                   spread_all_clocks,
  // Spread control
  output logic                   div_step_fine,
  output logic [5:0]             spread_width,
  output logic [1:0]             rate_shift,
  output logic                   spread_active,
  output logic                   load_sm_pulse,
  output logic                   fifo_reset,
  output logic                   wave_reset,
  output logic [6:0]             mod_position
);
  import sscc_pkg::*;

  sscc_main_s st;
  sscc_main_s next_st;

  logic [5:0] aw_word;
  logic [5:0] ar_word;
  logic       write_fire;
  logic       read_fire;
  logic       line_here;
  logic       mode_off;
  logic [5:0] base_width;
  logic [7:0] read_value;
  logic       read_hit;
  logic       wr_hit;
  logic       wr_enable_rise;
  logic       wr_load_bit;

  assign aw_word = s_axi_awaddr[7:2];
  assign ar_word = s_axi_araddr[7:2];

  // Address and data may arrive in either order; hold each until paired
  // Readies drop with ce so no handshake is taken while state is frozen
  assign s_axi_awready = ce && !st.aw_held && !st.bvalid;
  assign s_axi_wready  = ce && !st.w_held && !st.bvalid;
  assign s_axi_arready = ce && !st.rvalid;
  assign s_axi_bvalid  = st.bvalid;
  assign s_axi_bresp   = st.bresp;
  assign s_axi_rvalid  = st.rvalid;
  assign s_axi_rresp   = st.rresp;
  assign s_axi_rdata   = {24'h000000, st.rdata};

  assign write_fire = st.aw_held && st.w_held && !st.bvalid;
  assign read_fire  = s_axi_arvalid && s_axi_arready;
  assign mode_off   = st.load_resets[`SSCC_MODE_MSB:`SSCC_MODE_LSB]
                      == `SSCC_MODE_OFF;
  assign line_here  = line_sync_pulse;

  // Read decode; the load bit shows whatever is stored, cleared by pulse
  always_comb
  begin
    read_value = 8'h00;
    read_hit   = 1'b1;
    unique case (ar_word)
      `SSCC_IDX_PLL_ONE:     read_value = st.pll_one;
      `SSCC_IDX_PLL_TWO:     read_value = st.pll_two;
      `SSCC_IDX_SHAPE:       read_value = st.shape;
      `SSCC_IDX_LOAD_RESETS: read_value = st.load_resets; // R18
      `SSCC_IDX_STATUS:
        read_value = {6'h00, st.seq == SSCC_WAIT_SYNC,
                      st.seq == SSCC_RUN};
      default:               read_hit   = 1'b0;
    endcase
  end

  always_comb
  begin
    next_st        = st;
    wr_hit         = 1'b0;
    wr_enable_rise = 1'b0;
    wr_load_bit    = 1'b0;

    // Write address and data capture
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_st.aw_held = 1'b1;
      next_st.aw_idx  = aw_word;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_st.w_held  = 1'b1;
      next_st.w_data  = s_axi_wdata[7:0];
      next_st.w_lane0 = s_axi_wstrb[0];
    end

    // One-cycle strobes default low
    next_st.load_pulse = 1'b0;
    next_st.fifo_reset = 1'b0;
    next_st.wave_reset = 1'b0;

    // Self-clearing load: stored bit becomes a pulse then drops
    if (st.load_resets[`SSCC_LOAD_BIT])
    begin
      next_st.load_pulse = 1'b1; // R12
      next_st.load_resets[`SSCC_LOAD_BIT] = 1'b0; // R18
    end

    if (write_fire)
    begin
      next_st.aw_held = 1'b0;
      next_st.w_held  = 1'b0;
      next_st.bvalid  = 1'b1;
      wr_hit = st.aw_idx == `SSCC_IDX_PLL_ONE ||
               st.aw_idx == `SSCC_IDX_PLL_TWO ||
               st.aw_idx == `SSCC_IDX_SHAPE ||
               st.aw_idx == `SSCC_IDX_LOAD_RESETS ||
               st.aw_idx == `SSCC_IDX_STATUS;
      next_st.bresp = wr_hit ? `SSCC_RESP_OKAY : `SSCC_RESP_SLVERR;
      // Only byte lane 0 carries register bits
      if (st.w_lane0)
      begin
        unique case (st.aw_idx)
          `SSCC_IDX_PLL_ONE: next_st.pll_one = st.w_data; // R1 R2
          `SSCC_IDX_PLL_TWO:
            next_st.pll_two = {3'h0, st.w_data[4:0]};
          `SSCC_IDX_SHAPE:
          begin
            wr_enable_rise = st.w_data[`SSCC_ENABLE_BIT] &&
                             !st.shape[`SSCC_ENABLE_BIT]; // R11
            next_st.shape = st.w_data;
          end
          `SSCC_IDX_LOAD_RESETS:
          begin
            wr_load_bit = st.w_data[`SSCC_LOAD_BIT];
            next_st.load_resets = st.w_data;
            // Load bit takes the written value, so a write of 0 clears it
            next_st.load_resets[`SSCC_LOAD_BIT] = wr_load_bit; // R12
          end
          default: ;
        endcase
      end
      // Enable rising also requests a load, same path as the load bit
      if (wr_enable_rise)
        next_st.load_resets[`SSCC_LOAD_BIT] = 1'b1; // R11
    end

    if (st.bvalid && s_axi_bready)
      next_st.bvalid = 1'b0;

    // Read channel
    if (read_fire)
    begin
      next_st.rvalid = 1'b1;
      next_st.rdata  = read_value;
      next_st.rresp  = read_hit ? `SSCC_RESP_OKAY : `SSCC_RESP_SLVERR;
    end
    else if (st.rvalid && s_axi_rready)
      next_st.rvalid = 1'b0;

    // Start sequencer
    unique case (st.seq)
      SSCC_IDLE:
      begin
        if (st.load_pulse && st.shape[`SSCC_ENABLE_BIT] && !mode_off)
        begin
          next_st.wave_reset = 1'b1;
          if (st.shape[`SSCC_SYNC_EN_BIT])
            next_st.seq = SSCC_WAIT_SYNC; // R10
          else
          begin
            next_st.seq        = SSCC_RUN; // R10
            next_st.fifo_reset = 1'b1; // R13
          end
        end
      end
      SSCC_WAIT_SYNC:
      begin
        if (!st.shape[`SSCC_ENABLE_BIT] || mode_off)
          next_st.seq = SSCC_IDLE; // R11 R16
        else if (line_here)
        begin
          next_st.seq        = SSCC_RUN; // R10
          next_st.fifo_reset = 1'b1; // R13
          next_st.wave_reset = 1'b1;
        end
      end
      SSCC_RUN:
      begin
        if (!st.shape[`SSCC_ENABLE_BIT] || mode_off)
          next_st.seq = SSCC_IDLE; // R11 R16
        else if (st.load_pulse)
        begin
          // Reload restarts the sequence under current settings
          next_st.wave_reset = 1'b1; // R12
          if (st.shape[`SSCC_SYNC_EN_BIT])
            next_st.seq = SSCC_WAIT_SYNC;
          else
            next_st.fifo_reset = 1'b1; // R13
        end
        else if (line_here)
        begin
          next_st.fifo_reset = st.load_resets[`SSCC_FIFO_LINE_BIT]; // R13
          next_st.wave_reset = st.load_resets[`SSCC_WAVE_LINE_BIT]; // R15
        end
      end
      default: next_st.seq = SSCC_IDLE;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st             <= '0;
      st.pll_one     <= `SSCC_RST_PLL_ONE; // R2
      st.pll_two     <= `SSCC_RST_PLL_TWO;
      st.shape       <= `SSCC_RST_SHAPE;
      st.load_resets <= `SSCC_RST_LOAD_RESETS; // R16
      st.seq         <= SSCC_IDLE;
    end
    else if (ce)
      st <= next_st;
  end

  // Loop configuration straight from registers
  assign pll_range = st.pll_one[`SSCC_RANGE_MSB:`SSCC_RANGE_LSB]; // R1
  assign first_multiplier_loop_pump =
    st.pll_one[`SSCC_PUMP_MSB:`SSCC_PUMP_LSB]; // R2
  assign first_multiplier_loop_filter =
    st.pll_one[`SSCC_FILT_MSB:`SSCC_FILT_LSB]; // R2
  assign second_multiplier_loop_pump =
    st.pll_two[`SSCC_PUMP_MSB:`SSCC_PUMP_LSB];
  assign second_multiplier_loop_filter =
    st.pll_two[`SSCC_FILT_MSB:`SSCC_FILT_LSB];
  assign first_multiplier_loop_lock_force =
    st.load_resets[`SSCC_LOCK1_OVR_BIT];
  assign second_multiplier_loop_lock_force =
    st.load_resets[`SSCC_LOCK2_OVR_BIT];

  // Mode decode
  always_comb
  begin
    pll_enable        = 1'b1;
    multiply_enable   = 1'b1;
    spread_all_clocks = 1'b1;
    unique case (st.load_resets[`SSCC_MODE_MSB:`SSCC_MODE_LSB])
      `SSCC_MODE_ALL_NOMULT: multiply_enable = 1'b0; // R16
      `SSCC_MODE_OFF:
      begin
        pll_enable        = 1'b0; // R16
        multiply_enable   = 1'b0;
        spread_all_clocks = 1'b0;
      end
      `SSCC_MODE_ALL_MULT:   spread_all_clocks = 1'b1; // R16
      `SSCC_MODE_OUT_MULT:   spread_all_clocks = 1'b0; // R16
    endcase
  end

  // Spread shape decode
  always_comb
  begin
    unique case (st.shape[`SSCC_WIDTH_MSB:`SSCC_WIDTH_LSB])
      2'h0: base_width = `SSCC_WIDTH_5P0; // R9
      2'h1: base_width = `SSCC_WIDTH_2P5; // R9
      2'h2: base_width = `SSCC_WIDTH_1P25; // R9
      2'h3: base_width = `SSCC_WIDTH_0P625; // R9
    endcase
    // Reserved rate falls back to 1x so no undefined rate appears
    unique case (st.shape[`SSCC_RATE_MSB:`SSCC_RATE_LSB])
      `SSCC_RATE_X2: rate_shift = 2'h1; // R5
      `SSCC_RATE_X4: rate_shift = 2'h2; // R5
      default:       rate_shift = 2'h0; // R5 R19
    endcase
  end

  assign spread_width  = st.shape[`SSCC_GAIN_BIT] ?
                         {base_width[4:0], 1'b0} : base_width; // R8
  assign div_step_fine = st.shape[`SSCC_BOOST_BIT]; // R7
  assign spread_active = st.seq == SSCC_RUN;
  assign load_sm_pulse = st.load_pulse;
  assign fifo_reset    = st.fifo_reset;
  assign wave_reset    = st.wave_reset;

  sscc_spread_wave
  #(
    .TICK_CYCLES (TICK_CYCLES)
  )
  u_wave
  (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .ce         (ce),
    .run        (spread_active),
    .wave_reset (st.wave_reset), // R15
    .amp        ({1'b0, spread_width[5:1]}),
    .rate_shift (rate_shift),
    .max_rate   (st.load_resets[`SSCC_MAX_RATE_BIT]),
    .position   (mod_position)
  );

endmodule // sscc_top

// file: verif/sscc_top_sva.sv
// Purpose: Port-level checks for the spread clock control block.
// Assumes: ce stays high whenever the checks matter.
// Notes:   Bound to sscc_top from the testbench top file.
`timescale 1ns/100ps
module sscc_top_sva
(
  // Clock, reset, enable
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       ce,
  // Register bus
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic       s_axi_rvalid,
  input wire logic       s_axi_rready,
  // Line timing and spread control
  input wire logic       line_sync_pulse,
  input wire logic       pll_enable,
  input wire logic       multiply_enable,
  input wire logic       spread_all_clocks,
  input wire logic [5:0] spread_width,
  input wire logic [1:0] rate_shift,
  input wire logic       spread_active,
  input wire logic       load_sm_pulse,
  input wire logic       fifo_reset,
  input wire logic       wave_reset
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn || !ce);

  // Every line-side reset needs a load or a line pulse just before
  sequence cause_s;
    $past(load_sm_pulse) || $past(line_sync_pulse);
  endsequence

  pulse_one_a: assert property (load_sm_pulse |=> !load_sm_pulse)
    else $error("load pulse longer than one cycle");
  rate_legal_a: assert property (rate_shift != 2'h3)
    else $error("reserved rate reached the waveform");
  width_legal_a: assert property ($onehot(spread_width)
    && spread_width >= 6'h02) else $error("spread width out of set");
  mode_off_a: assert property (!pll_enable
    |-> !multiply_enable && !spread_all_clocks) else $error("mode decode");
  mode_idle_a: assert property (!pll_enable |=> !spread_active)
    else $error("spread kept running with loops off");
  start_resets_a: assert property ($rose(spread_active)
    |-> fifo_reset && wave_reset) else $error("start without resets");
  start_cause_a: assert property ($rose(spread_active) |-> cause_s)
    else $error("spread started without cause");
  fifo_cause_a: assert property (fifo_reset |-> cause_s)
    else $error("stray fifo reset");
  wave_cause_a: assert property (wave_reset |-> cause_s)
    else $error("stray waveform reset");
  write_busy_a: assert property (s_axi_bvalid
    |-> !s_axi_awready && !s_axi_wready) else $error("write not refused");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
endmodule // sscc_top_sva

// file: verif/testbench.sv
// Purpose: Self-checking bench for the spread clock control block.
// Assumes: ce held high; short modulation tick for run time.
// Notes:   Pulse outputs are counted and compared as deltas.
`timescale 1ns/100ps
module testbench;
  logic        aclk = 1'h0;
  logic        aresetn = 1'h0;
  logic        ce = 1'h1;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'h1;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
  logic        s_axi_bready = 1'h0, s_axi_rready = 1'h0;
  logic        s_axi_arvalid = 1'h0, line_sync_pulse = 1'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rate_shift;
  logic [2:0]  pll_range, first_multiplier_loop_filter;
  logic [2:0]  second_multiplier_loop_filter;
  logic [1:0]  first_multiplier_loop_pump, second_multiplier_loop_pump;
  logic        first_multiplier_loop_lock_force;
  logic        second_multiplier_loop_lock_force;
  logic        pll_enable, multiply_enable, spread_all_clocks;
  logic        div_step_fine, spread_active, load_sm_pulse;
  logic        fifo_reset, wave_reset;
  logic [5:0]  spread_width;
  logic [6:0]  mod_position;
  int          bad_count = 0, check_count = 0;
  int          fifo_n = 0, wave_n = 0, load_n = 0;
  wire  [7:0]  one_out = {pll_range, first_multiplier_loop_pump,
                          first_multiplier_loop_filter};
  wire  [4:0]  two_out = {second_multiplier_loop_pump,
                          second_multiplier_loop_filter};
  wire  [2:0]  mode_out = {pll_enable, multiply_enable, spread_all_clocks};
  wire  [1:0]  lock_out = {second_multiplier_loop_lock_force,
                           first_multiplier_loop_lock_force};

  sscc_top #(.TICK_CYCLES(8)) sscc_top_inst (.*);

  always #20 aclk = ~aclk;

  // Counted mid-cycle, clear of the edge at which the scenarios read them
  always @(negedge aclk)
  begin
    fifo_n += int'(fifo_reset === 1'h1);
    wave_n += int'(wave_reset === 1'h1);
    load_n += int'(load_sm_pulse === 1'h1);
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Address and data offered together, each released once taken
  task automatic wr(input logic [7:0] a, d, input logic [1:0] er);
    logic aw_done;
    logic w_done;
    aw_done = 1'h0;
    w_done = 1'h0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    while (!(aw_done && w_done))
    begin
      @(posedge aclk);
      aw_done = aw_done || s_axi_awready === 1'h1;
      w_done = w_done || s_axi_wready === 1'h1;
      s_axi_awvalid <= !aw_done;
      s_axi_wvalid <= !w_done;
    end
    while (s_axi_bvalid !== 1'h1) @(posedge aclk);
    check({30'h0, s_axi_bresp}, {30'h0, er});
    // Late bready exercises the response hold
    s_axi_bready <= 1'h1;
    @(posedge aclk);
    s_axi_bready <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [1:0] er,
                    output logic [31:0] d);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    @(posedge aclk);
    while (s_axi_arready !== 1'h1) @(posedge aclk);
    s_axi_arvalid <= 1'h0;
    while (s_axi_rvalid !== 1'h1) @(posedge aclk);
    d = s_axi_rdata;
    check({30'h0, s_axi_rresp}, {30'h0, er});
    s_axi_rready <= 1'h1;
    @(posedge aclk);
    s_axi_rready <= 1'h0;
  endtask

  task automatic line;
    line_sync_pulse <= 1'h1;
    @(posedge aclk);
    line_sync_pulse <= 1'h0;
  endtask

  task automatic t_reset;
    logic [31:0] d;
    rd(8'h60, 2'h0, d);
    check(d, 32'hf8);
    check({24'h0, one_out}, 32'hf8);
    check({25'h0, mod_position}, 32'h8);
    rd(8'h64, 2'h0, d);
    check(d, 32'h18);
    rd(8'h68, 2'h0, d);
    check(d, 32'h00);
    rd(8'h6c, 2'h0, d);
    check(d, 32'h02);
    check({29'h0, mode_out}, 32'h0);
    wr(8'h60, 8'h5a, 2'h0);
    check({24'h0, one_out}, 32'h5a);
    wr(8'h64, 8'hff, 2'h0);
    rd(8'h64, 2'h0, d);
    check(d, 32'h1f);
    wr(8'h64, 8'h07, 2'h0);
    check({27'h0, two_out}, 32'h07);
    $display("t_reset done");
  endtask

  task automatic t_shape;
    logic [7:0] v;
    logic [1:0] r;
    logic [5:0] w;
    for (int i = 0; i < 256; i += 4)
    begin
      v = i[7:0];
      wr(8'h68, v, 2'h0);
      r = (v[7:6] == 2'h3) ? 2'h0 : v[7:6];
      w = (6'h10 >> v[3:2]) << v[4];
      check({30'h0, rate_shift}, {30'h0, r});
      check({26'h0, spread_width}, {26'h0, w});
      check({31'h0, div_step_fine}, {31'h0, v[5]});
    end
    $display("t_shape done");
  endtask

  task automatic t_mode;
    logic [2:0] m [4] = '{3'h6, 3'h7, 3'h0, 3'h5};
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h6c, 8'h18 | i[7:0], 2'h0);
      check({29'h0, mode_out}, {29'h0, m[i]});
      check({30'h0, lock_out}, 32'h3);
    end
    wr(8'h6c, 8'h01, 2'h0);
    $display("t_mode done");
  endtask

  task automatic t_start;
    logic [31:0] d;
    int f, w, l;
    f = fifo_n;
    w = wave_n;
    l = load_n;
    wr(8'h68, 8'h01, 2'h0);
    for (int i = 0; i < 20 && spread_active !== 1'h1; i++) @(posedge aclk);
    check({31'h0, spread_active}, 32'h1);
    check(32'(load_n - l), 32'h1);
    check(32'(fifo_n - f), 32'h1);
    check(32'(wave_n - w), 32'h1);
    rd(8'h6c, 2'h0, d);
    check(d, 32'h01);
    rd(8'h80, 2'h0, d);
    check(d, 32'h1);
    $display("t_start done");
  endtask

  task automatic t_line;
    logic [7:0] v [4] = '{8'h01, 8'h60, 8'h21, 8'h40};
    int f, w;
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h6c, v[i], 2'h0);
      f = fifo_n;
      w = wave_n;
      line;
      repeat (3) @(posedge aclk);
      check(32'(fifo_n - f), {31'h0, v[i][6]});
      check(32'(wave_n - w), {31'h0, v[i][5]});
    end
    wr(8'h6c, 8'h02, 2'h0);
    check({31'h0, spread_active}, 32'h0);
    wr(8'h6c, 8'h01, 2'h0);
    $display("t_line done");
  endtask

  task automatic t_sync;
    logic [31:0] d;
    wr(8'h68, 8'h00, 2'h0);
    wr(8'h68, 8'h03, 2'h0);
    repeat (10) @(posedge aclk);
    check({31'h0, spread_active}, 32'h0);
    rd(8'h80, 2'h0, d);
    check(d, 32'h2);
    line;
    repeat (2) @(posedge aclk);
    check({31'h0, spread_active}, 32'h1);
    $display("t_sync done");
  endtask

  task automatic t_load;
    logic [31:0] d;
    int l;
    l = load_n;
    wr(8'h6c, 8'h81, 2'h0);
    repeat (3) @(posedge aclk);
    check(32'(load_n - l), 32'h1);
    rd(8'h6c, 2'h0, d);
    check(d, 32'h01);
    rd(8'h80, 2'h0, d);
    check(d, 32'h2);
    wr(8'h70, 8'h55, 2'h2);
    rd(8'h74, 2'h2, d);
    check(d, 32'h0);
    rd(8'h68, 2'h0, d);
    check(d, 32'h03);
    $display("t_load done");
  endtask

  initial
  begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    t_reset;
    t_shape;
    t_mode;
    t_start;
    t_line;
    t_sync;
    t_load;
    end_of_test;
  end

  // Over ten times the expected run length of about 400 cycles
  initial
  begin
    repeat (6000) @(posedge aclk);
    bad_count++;
    end_of_test;
  end
endmodule // testbench

bind sscc_top sscc_top_sva sscc_top_sva_inst (.*);
